// >>> inc/mmda_pkg.sv
// shared types, address map and field positions of the memory map decoder
package mmda_pkg;
    localparam int NUM_REQ  = 3;
    localparam int NUM_CORE = 2;
    localparam int REQ_DMA  = 2;
    localparam int SD_BANKS = 4;

    // external memory windows
    localparam logic [31:0] SD_BASE    = 32'h0000_0000;
    localparam logic [31:0] SD_LIMIT   = 32'h2000_0000; // 512M ceiling
    localparam logic [31:0] SD_MIN_SZ  = 32'h0100_0000; // 16M, code 0
    localparam logic [31:0] AS_BASE    = 32'h2000_0000;
    localparam logic [31:0] AS_LIMIT   = 32'h3000_0000;
    localparam int          AS_SEG_LSB = 26;            // 64M segments

    // on-chip memory windows
    localparam logic [31:0] L2_BASE      = 32'hFEB0_0000;
    localparam logic [31:0] L2_SIZE      = 32'h0002_0000; // 128K
    localparam int          L2_BEAT_LSB  = 3;             // 64-bit beats
    localparam logic [9:0]  L1_WIN0      = 10'h3FE;       // addr[31:22]
    localparam logic [9:0]  L1_WIN1      = 10'h3FD;
    localparam logic [1:0]  L1_SEL_D     = 2'h0;          // addr[21:20]
    localparam logic [1:0]  L1_SEL_I     = 2'h2;
    localparam logic [1:0]  L1_SEL_S     = 2'h3;
    localparam logic [19:0] L1D_SIZE     = 20'h1_0000;    // 4 x 16K
    localparam logic [19:0] L1I_SIZE     = 20'h0_8000;    // 2 x 16K
    localparam logic [19:0] SCR_SIZE     = 20'h0_1000;    // 4K
    localparam int          BANK_LSB     = 14;            // 16K banks
    localparam int          SUB_LSB      = 12;            // 4K sub-banks
    localparam logic [1:0]  L1D_CACHE_BK = 2'h2;          // banks below
    localparam logic [10:0] SYS_WIN      = 11'h7FE;       // addr[31:21]
    localparam logic [10:0] CORE_WIN     = 11'h7FF;

    typedef enum logic [2:0] {
        MODE_USER  = 3'b001,
        MODE_SUPER = 3'b010,
        MODE_EMU   = 3'b100
    } mmda_mode_t;

    typedef enum logic [3:0] {
        TGT_NONE    = 4'h0,
        TGT_SDRAM   = 4'h1,
        TGT_ASYNC   = 4'h2,
        TGT_L1I     = 4'h3,
        TGT_L1D     = 4'h4,
        TGT_SCR     = 4'h5,
        TGT_L2      = 4'h6,
        TGT_SYSREG  = 4'h7,
        TGT_COREREG = 4'h8
    } mmda_tgt_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        fetch;
        mmda_mode_t  mode;
        logic [31:0] addr;
    } mmda_req_t;

    typedef struct packed {
        logic [1:0] icache_en;
        logic [1:0] dcache_en;
        logic       sys_visible;
        logic [3:0] sd_en;
        logic [7:0] sd_size;
    } mmda_cfg_t;

    typedef struct packed {
        mmda_tgt_t   tgt;
        logic        core;
        logic [1:0]  unit;
        logic [1:0]  sub;
        logic [13:0] beat;
    } mmda_hit_t;

    typedef struct packed {
        logic      done;
        logic      retry;
        logic      err;
        logic      wr_commit;
        mmda_hit_t hit;
    } mmda_rsp_t;

    typedef struct packed {
        mmda_rsp_t [NUM_REQ-1:0] rsp;
        logic [1:0]              l2_gnt;
    } mmda_st_t;

    typedef struct packed {
        logic last;
        logic phase;
    } mmda_arb_st_t;
endpackage : mmda_pkg

// >>> logic/mmda_decode.sv
// address decoder: one flat space, each address onto one target
module mmda_decode
(
    input  wire logic [31:0]         addr,
    input  mmda_pkg::mmda_cfg_t      cfg,
    output mmda_pkg::mmda_hit_t      hit
);
    import mmda_pkg::*;

    logic [31:0] sd_end [SD_BANKS+1];

    // banks stacked back to back, so holes never appear between them
    always_comb
    begin
        sd_end[0] = SD_BASE;
        for (int b = 0; b < SD_BANKS; b++)
        begin
            sd_end[b+1] = sd_end[b]
                + (cfg.sd_en[b] ? (SD_MIN_SZ << cfg.sd_size[2*b +: 2])
                                : 32'h0);
        end
    end

    // windows never overlap, so first match is the only match
    always_comb
    begin
        hit      = '0;
        hit.tgt  = TGT_NONE;
        hit.sub  = addr[SUB_LSB +: 2];
        hit.beat = addr[L2_BEAT_LSB +: 14];
        if (addr < sd_end[SD_BANKS])
        begin
            hit.tgt = TGT_SDRAM;
            for (int b = SD_BANKS - 1; b >= 0; b--)
            begin
                if (addr < sd_end[b+1])
                    hit.unit = 2'(b);
            end
        end
        else if (addr >= AS_BASE && addr < AS_LIMIT)
        begin
            hit.tgt  = TGT_ASYNC;
            hit.unit = addr[AS_SEG_LSB +: 2];
        end
        else if (addr >= L2_BASE && addr < L2_BASE + L2_SIZE)
            hit.tgt = TGT_L2;
        else if (addr[31:21] == SYS_WIN)
            hit.tgt = TGT_SYSREG;
        else if (addr[31:21] == CORE_WIN)
            hit.tgt = TGT_COREREG;
        else if (addr[31:22] == L1_WIN0 || addr[31:22] == L1_WIN1)
        begin
            hit.core = (addr[31:22] == L1_WIN1);
            hit.unit = addr[BANK_LSB +: 2];
            unique case (addr[21:20])
                L1_SEL_D: if (addr[19:0] < L1D_SIZE) hit.tgt = TGT_L1D;
                L1_SEL_I: if (addr[19:0] < L1I_SIZE) hit.tgt = TGT_L1I;
                L1_SEL_S: if (addr[19:0] < SCR_SIZE) hit.tgt = TGT_SCR;
                default:  hit.tgt = TGT_NONE;
            endcase
        end
    end
endmodule : mmda_decode

// >>> logic/mmda_l2_arb.sv
// two-core arbiter for the shared half-rate L2 port
module mmda_l2_arb
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [1:0] want,
    output logic            slot,
    output logic [1:0]      gnt
);
    import mmda_pkg::*;

    mmda_arb_st_t st_q;
    mmda_arb_st_t st_d;

    // grant only in the L2 slot; alternate under contention
    always_comb
    begin
        st_d  = st_q;
        gnt   = 2'h0;
        slot  = !st_q.phase;
        if (slot)
        begin
            if (want == 2'h3)
                gnt = st_q.last ? 2'h1 : 2'h2;
            else
                gnt = want;
            if (gnt != 2'h0)
                st_d.last = gnt[1];
        end
        st_d.phase = !st_q.phase;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else if (ce)
            st_q <= st_d;
    end
endmodule : mmda_l2_arb

// >>> logic/mmda_top.sv
// memory map decode and access control for two cores and dma
// Operation
// - flat 4G byte space, 32-bit addresses
// - regions never overlap, one target each
// - sdram banks 16M to 128M, 512M total
// - sdram banks packed back to back
// - each async bank owns fixed 64M segment
// - control registers mapped near top, two blocks
// - core registers: owning core, supervisor or emulation only
// - system registers: supervisor or emulation core, dma configurable
// - scratchpad: core data only, no dma
// - L1 instruction: 16K sram, 16K cache-or-sram
// - L1 data: two cache-capable banks, two sram
// - core and dma run concurrently in different sub-banks
// - instruction memory holds instructions only
// - L2 128K unified, half core rate
// - cores arbitrate one 64-bit L2 path
// - each core has its own core registers
// - user mode denied restricted resources
module mmda_top
(
    input  wire logic                                sys_clk,
    input  wire logic                                rst_n,
    input  wire logic                                ce,
    input  mmda_pkg::mmda_req_t [mmda_pkg::NUM_REQ-1:0] req,
    input  mmda_pkg::mmda_cfg_t                      cfg,
    output mmda_pkg::mmda_rsp_t [mmda_pkg::NUM_REQ-1:0] rsp,
    output logic [1:0]                               l2_gnt
);
    import mmda_pkg::*;

    mmda_st_t           st_q;
    mmda_st_t           st_d;
    mmda_hit_t          hit [NUM_REQ];
    logic [NUM_REQ-1:0] refuse;
    logic [NUM_REQ-1:0] busy;
    logic [1:0]         l2_want;
    logic [1:0]         l2_gnt_c;
    logic               l2_slot;

    // one decoder per requester, all decode in the same cycle
    for (genvar i = 0; i < NUM_REQ; i++)
    begin : g_dec
        mmda_decode u_dec
        (
            .addr (req[i].addr),
            .cfg  (cfg),
            .hit  (hit[i])
        );
    end

    // shared L2 path, one core per slot
    mmda_l2_arb u_arb
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .want    (l2_want),
        .slot    (l2_slot),
        .gnt     (l2_gnt_c)
    );

    // access checks by requester, mode and target
    always_comb
    begin
        logic core_rq;
        logic priv;
        core_rq = 1'b0;
        priv    = 1'b0;
        refuse  = '0;
        l2_want = '0;
        for (int i = 0; i < NUM_REQ; i++)
        begin
            core_rq = (i != REQ_DMA);
            // emulation counts as privileged
            priv = (req[i].mode != MODE_USER);
            unique case (hit[i].tgt)
                TGT_NONE:
                    refuse[i] = 1'b1;
                TGT_COREREG:
                    refuse[i] = !core_rq || !priv;
                TGT_SYSREG:
                    refuse[i] = core_rq ? !priv
                                        : !cfg.sys_visible;
                TGT_SCR:
                    refuse[i] = !core_rq || req[i].fetch;
                TGT_L1I:
                    refuse[i] = (core_rq && !req[i].fetch)
                        || (hit[i].unit[0]
                            && cfg.icache_en[hit[i].core]);
                TGT_L1D:
                    refuse[i] = req[i].fetch
                        || (hit[i].unit < L1D_CACHE_BK
                            && cfg.dcache_en[hit[i].core]);
                default:
                    refuse[i] = 1'b0;
            endcase
            // a fetch never writes
            if (req[i].fetch && req[i].write)
                refuse[i] = 1'b1;
        end
        for (int c = 0; c < NUM_CORE; c++)
        begin
            l2_want[c] = req[c].valid && !refuse[c]
                && (hit[c].tgt == TGT_L2);
        end
    end

    // stalls: L2 slot and grant, L1 sub-bank clash
    always_comb
    begin
        busy = '0;
        for (int i = 0; i < NUM_REQ; i++)
        begin
            if (hit[i].tgt == TGT_L2)
            begin
                // dma uses the system side, only the slot matters
                if (i == REQ_DMA)
                    busy[i] = !l2_slot;
                else
                    busy[i] = !l2_gnt_c[i[0]];
            end
        end
        // core keeps its sub-bank, dma retries; other sub-banks run free
        for (int c = 0; c < NUM_CORE; c++)
        begin
            if (req[c].valid && !refuse[c]
                && (hit[c].tgt == TGT_L1I || hit[c].tgt == TGT_L1D)
                && hit[c].tgt == hit[REQ_DMA].tgt
                && hit[c].core == hit[REQ_DMA].core
                && hit[c].unit == hit[REQ_DMA].unit
                && hit[c].sub == hit[REQ_DMA].sub)
            begin
                busy[REQ_DMA] = 1'b1;
            end
        end
    end

    // one answer per requester per cycle
    always_comb
    begin
        st_d        = st_q;
        st_d.l2_gnt = l2_gnt_c;
        for (int i = 0; i < NUM_REQ; i++)
        begin
            st_d.rsp[i]     = '0;
            st_d.rsp[i].hit = hit[i];
            // same address, private copy of the asking core
            if (hit[i].tgt == TGT_COREREG)
                st_d.rsp[i].hit.core = i[0];
            if (req[i].valid)
            begin
                // refusal beats a stall: no point retrying
                st_d.rsp[i].err   = refuse[i];
                st_d.rsp[i].retry = !refuse[i] && busy[i];
                st_d.rsp[i].done  = refuse[i] || !busy[i];
                st_d.rsp[i].wr_commit = req[i].write
                    && !refuse[i] && !busy[i];
            end
        end
    end

    // all state frozen while ce is low
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else if (ce)
            st_q <= st_d;
    end

    // outputs straight from the state flops
    assign rsp    = st_q.rsp;
    assign l2_gnt = st_q.l2_gnt;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // unmapped address is refused
    property p_unmapped;
        ce && req[0].valid && hit[0].tgt == TGT_NONE
        |=> rsp[0].err && rsp[0].done && !rsp[0].wr_commit;
    endproperty
    a_unmapped:
        assert property (p_unmapped)
        else $error("unmapped address not refused");

    // dma never reaches core registers
    property p_corereg_dma;
        ce && req[REQ_DMA].valid && hit[REQ_DMA].tgt == TGT_COREREG
        |=> rsp[REQ_DMA].err && !rsp[REQ_DMA].wr_commit;
    endproperty
    a_corereg_dma:
        assert property (p_corereg_dma)
        else $error("dma reached core registers");

    // user mode core is kept off system registers
    property p_sys_user;
        ce && req[0].valid && req[0].mode == MODE_USER
        && hit[0].tgt == TGT_SYSREG
        |=> rsp[0].err;
    endproperty
    a_sys_user:
        assert property (p_sys_user)
        else $error("user mode reached system registers");

    // dma visibility of system registers follows the strap
    property p_sys_dma;
        ce && req[REQ_DMA].valid && hit[REQ_DMA].tgt == TGT_SYSREG
        && !(req[REQ_DMA].fetch && req[REQ_DMA].write)
        |=> rsp[REQ_DMA].err == !$past(cfg.sys_visible);
    endproperty
    a_sys_dma:
        assert property (p_sys_dma)
        else $error("system register visibility wrong for dma");

    // scratchpad closed to dma
    property p_scr_dma;
        ce && req[REQ_DMA].valid && hit[REQ_DMA].tgt == TGT_SCR
        |=> rsp[REQ_DMA].err;
    endproperty
    a_scr_dma:
        assert property (p_scr_dma)
        else $error("dma reached scratchpad");

    // core data access to instruction memory refused
    property p_l1i_data;
        ce && req[1].valid && !req[1].fetch && hit[1].tgt == TGT_L1I
        |=> rsp[1].err;
    endproperty
    a_l1i_data:
        assert property (p_l1i_data)
        else $error("data access reached instruction memory");

    // cache-owned data banks are not sram
    property p_l1d_cache;
        ce && req[0].valid && hit[0].tgt == TGT_L1D
        && hit[0].unit < L1D_CACHE_BK && cfg.dcache_en[hit[0].core]
        |=> rsp[0].err;
    endproperty
    a_l1d_cache:
        assert property (p_l1d_cache)
        else $error("cache bank answered as sram");

    // only one core on the L2 path at a time
    property p_l2_share;
        !(rsp[0].done && !rsp[0].err && rsp[0].hit.tgt == TGT_L2
          && rsp[1].done && !rsp[1].err && rsp[1].hit.tgt == TGT_L2);
    endproperty
    a_l2_share:
        assert property (p_l2_share)
        else $error("both cores granted the L2 path");

    // a grant is followed by an idle half-rate slot
    property p_l2_half;
        ce && l2_gnt != 2'h0 |=> l2_gnt == 2'h0;
    endproperty
    a_l2_half:
        assert property (p_l2_half)
        else $error("L2 granted in back to back cycles");

    // dma yields a sub-bank the core is using
    property p_subbank;
        ce && req[0].valid && req[REQ_DMA].valid && !refuse[0]
        && hit[0].tgt == TGT_L1D && hit[REQ_DMA] == hit[0]
        |=> !rsp[REQ_DMA].wr_commit
            && (rsp[REQ_DMA].retry || rsp[REQ_DMA].err);
    endproperty
    a_subbank:
        assert property (p_subbank)
        else $error("dma entered a busy sub-bank");

    // core registers answered from the asking core's copy
    property p_corereg_own;
        ce && req[1].valid && hit[1].tgt == TGT_COREREG
        |=> rsp[1].hit.core == 1'b1 && rsp[1].hit.tgt == TGT_COREREG;
    endproperty
    a_corereg_own:
        assert property (p_corereg_own)
        else $error("core register copy of wrong core");

    // sdram hits never pass the 512M ceiling
    property p_sd_limit;
        ce && req[0].valid && hit[0].tgt == TGT_SDRAM
        |-> req[0].addr < SD_LIMIT;
    endproperty
    a_sd_limit:
        assert property (p_sd_limit)
        else $error("sdram decode past its ceiling");

    // user mode core is kept off core registers
    property p_corereg_user;
        ce && req[0].valid && req[0].mode == MODE_USER
        && hit[0].tgt == TGT_COREREG |=> rsp[0].err && !rsp[0].wr_commit;
    endproperty
    a_corereg_user:
        assert property (p_corereg_user)
        else $error("user mode reached core registers");

    // no instruction fetch from the scratchpad
    property p_scr_fetch;
        ce && req[1].valid && req[1].fetch && hit[1].tgt == TGT_SCR
        |=> rsp[1].err;
    endproperty
    a_scr_fetch:
        assert property (p_scr_fetch)
        else $error("fetch reached scratchpad");

    // cache half of instruction memory is not sram
    property p_l1i_cache;
        ce && req[0].valid && hit[0].tgt == TGT_L1I
        && hit[0].unit[0] && cfg.icache_en[hit[0].core]
        |=> rsp[0].err;
    endproperty
    a_l1i_cache:
        assert property (p_l1i_cache)
        else $error("instruction cache half answered as sram");

    // a write dressed as a fetch never lands
    property p_fetch_write;
        ce && req[REQ_DMA].valid && req[REQ_DMA].fetch && req[REQ_DMA].write
        |=> rsp[REQ_DMA].err && !rsp[REQ_DMA].wr_commit;
    endproperty
    a_fetch_write:
        assert property (p_fetch_write)
        else $error("fetch with write was not refused");

    // no request, no answer and no write
    property p_idle_quiet;
        ce && !req[1].valid
        |=> !rsp[1].done && !rsp[1].retry && !rsp[1].wr_commit;
    endproperty
    a_idle_quiet:
        assert property (p_idle_quiet)
        else $error("answer without a request");

    // dma to L2 outside the half-rate slot waits
    property p_dma_slot;
        ce && req[REQ_DMA].valid && hit[REQ_DMA].tgt == TGT_L2 && !l2_slot
        |=> !rsp[REQ_DMA].wr_commit
            && (rsp[REQ_DMA].retry || rsp[REQ_DMA].err);
    endproperty
    a_dma_slot:
        assert property (p_dma_slot)
        else $error("dma served by L2 outside its slot");
endmodule : mmda_top

// >>> verification/memory_map_decode_and_access_tb.sv
// self-checking bench for the memory map decoder with requester models
module memory_map_decode_and_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mmda_pkg::*;

    logic                    sys_clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic                    ce = 1'b1;
    logic [NUM_REQ-1:0]      go = '0;
    logic [NUM_REQ-1:0]      busy;
    logic [1:0]              l2_gnt;
    logic [1:0]              p;
    mmda_cfg_t               cfg;
    mmda_req_t [NUM_REQ-1:0] req;
    mmda_req_t [NUM_REQ-1:0] cmd;
    mmda_rsp_t [NUM_REQ-1:0] rsp;
    mmda_rsp_t [NUM_REQ-1:0] got;
    int                      err_count = 0;
    int                      n_checks = 0;
    int unsigned             seed;
    mmda_mode_t              modes [3] = '{MODE_USER, MODE_SUPER, MODE_EMU};
    logic [31:0]             tab [18] = '{
        32'h0000_0000, 32'h06FF_FFFC, 32'h0700_0000, 32'h0EFF_FFFC,
        32'h0F00_0000, 32'h2C00_0000, 32'h3000_0000, 32'hFEB1_FFF8,
        32'hFEB2_0000, 32'hFF80_FFFC, 32'hFF81_0000, 32'hFFB0_0FFC,
        32'hFFB0_1000, 32'hFFA0_4000, 32'hFF60_0000, 32'hFF40_4000,
        32'hFFC0_0000, 32'hFFE0_0000};

    mmda_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .req(req),
                    .cfg(cfg), .rsp(rsp), .l2_gnt(l2_gnt));

    // one model per requester: core0, core1, dma
    for (genvar g = 0; g < NUM_REQ; g++)
    begin : g_req
        mmda_req_model u_m (.sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd[g]),
                            .go(go[g]), .rsp(rsp[g]), .req(req[g]),
                            .busy(busy[g]), .got(got[g]));
    end

    // 125 MHz clock
    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // expected target; banks stack in order, absent ones take no space
    function automatic mmda_tgt_t exp_tgt(input logic [31:0] a,
                                          output logic [1:0] u);
        logic [31:0] end_a;
        end_a = SD_BASE;
        u = 2'h0;
        for (int b = 0; b < SD_BANKS; b++)
            if (cfg.sd_en[b])
            begin
                if (a >= end_a)
                    u = 2'(b);
                end_a += SD_MIN_SZ << cfg.sd_size[2*b+:2];
            end
        if (a < end_a)
            return TGT_SDRAM;
        u = a[27:26];
        if (a >= AS_BASE && a < AS_LIMIT)
            return TGT_ASYNC;
        if (a >= L2_BASE && a < L2_BASE + L2_SIZE)
            return TGT_L2;
        u = a[15:14];
        if (a[31:22] == L1_WIN0 || a[31:22] == L1_WIN1)
        begin
            if (a[21:20] == L1_SEL_D && a[19:0] < L1D_SIZE)
                return TGT_L1D;
            u = {1'b0, a[14]};
            if (a[21:20] == L1_SEL_I && a[19:0] < L1I_SIZE)
                return TGT_L1I;
            if (a[21:20] == L1_SEL_S && a[19:0] < SCR_SIZE)
                return TGT_SCR;
        end
        if (a[31:21] == SYS_WIN)
            return TGT_SYSREG;
        if (a[31:21] == CORE_WIN)
            return TGT_COREREG;
        return TGT_NONE;
    endfunction : exp_tgt

    // expected refusal from requester, mode and configuration
    function automatic logic exp_err(input int i, input mmda_req_t r,
                                     input mmda_tgt_t t);
        logic sup;
        logic dma;
        logic c;
        sup = (r.mode != MODE_USER);
        dma = (i == REQ_DMA);
        c = (r.addr[31:22] == L1_WIN1);
        if (r.fetch && r.write)
            return 1'b1;
        case (t)
            TGT_NONE:    return 1'b1;
            TGT_COREREG: return dma || !sup;
            TGT_SYSREG:  return dma ? !cfg.sys_visible : !sup;
            TGT_SCR:     return dma || r.fetch;
            TGT_L1I:     return (!dma && !r.fetch) ||
                                (cfg.icache_en[c] && r.addr[14]);
            TGT_L1D:     return r.fetch || (cfg.dcache_en[c] &&
                                r.addr[15:14] < L1D_CACHE_BK);
            default:     return 1'b0;
        endcase
    endfunction : exp_err

    task automatic verify(input int i);
        mmda_req_t  r;
        mmda_tgt_t  t;
        logic [1:0] u;
        logic       e;
        r = cmd[i];
        t = exp_tgt(r.addr, u);
        e = exp_err(i, r, t);
        check(got[i].done, 1'b1);
        check(got[i].err, e);
        check(got[i].hit.tgt, t);
        check(got[i].wr_commit, r.write && !e);
        if (t inside {TGT_SDRAM, TGT_ASYNC, TGT_L1D, TGT_L1I})
            check(got[i].hit.unit, u);
        if (t inside {TGT_L1D, TGT_L1I})
        begin
            check(got[i].hit.sub, r.addr[13:12]);
            check(got[i].hit.core, r.addr[31:22] == L1_WIN1);
        end
        if (t == TGT_L2)
            check(got[i].hit.beat, r.addr[16:3]);
        if (t == TGT_COREREG && i < NUM_CORE)
            check(got[i].hit.core, i[0]);
    endtask : verify

    task automatic start(input logic [2:0] m);
        go = m;
        @(posedge sys_clk);
        #1 go = '0;
    endtask : start

    task automatic finish(input logic [2:0] m);
        for (int k = 0; k < 40 && busy !== '0; k++)
            @(posedge sys_clk) #1;
        check(busy, '0);
        for (int j = 0; j < NUM_REQ; j++)
            if (m[j])
                verify(j);
    endtask : finish

    // every table address from every requester, mode and kind of access
    task automatic sweep();
        for (int k = 0; k < 18; k++)
            for (int i = 0; i < NUM_REQ; i++)
                for (int n = 0; n < 12; n++)
                begin
                    cmd[i] = '{1'b1, n[0], n[1], modes[n/4], tab[k]};
                    start(3'(1 << i));
                    finish(3'(1 << i));
                end
    endtask : sweep

    // core and dma in one cycle: same sub-bank retries dma only
    task automatic clash(input logic [31:0] a2, input logic [2:0] exp);
        cmd[0] = '{1'b1, 1'b0, 1'b0, MODE_SUPER, 32'hFF80_1000};
        cmd[2] = '{1'b1, 1'b0, 1'b0, MODE_SUPER, a2};
        start(3'b101);
        @(posedge sys_clk) #1;
        check({rsp[2].retry, rsp[2].done, rsp[0].done}, exp);
        finish(3'b101);
    endtask : clash

    initial
    begin
        #200000;
        err_count++;
        conclude();
    end

    initial
    begin
        cmd = '0;
        cfg = '{2'b00, 2'b00, 1'b0, 4'hF, 8'hE4};
        seed = $urandom(52);
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        @(posedge sys_clk) #1;
        sweep();
        cfg = '{2'b01, 2'b10, 1'b1, 4'hA, 8'($urandom)};
        sweep();
        clash(32'hFF80_1000, 3'b101);
        clash(32'hFF80_2000, 3'b011);
        // frozen clock enable: request held, nothing taken or written
        ce = 1'b0;
        cmd[0] = '{1'b1, 1'b1, 1'b0, MODE_SUPER, 32'h0000_0100};
        start(3'b001);
        repeat (4) @(posedge sys_clk) #1;
        check({busy[0], rsp[0].done, rsp[0].wr_commit}, 3'b100);
        ce = 1'b1;
        finish(3'b001);
        // both cores on the shared L2 path: one grant per slot at most
        repeat (3)
        begin
            cmd[0] = '{1'b1, 1'b0, 1'b0, MODE_SUPER, 32'hFEB0_0008};
            cmd[1] = '{1'b1, 1'b1, 1'b0, MODE_SUPER, 32'hFEB1_0010};
            start(3'b011);
            p = 2'b00;
            repeat (6)
            begin
                @(posedge sys_clk) #1;
                check(l2_gnt & p, 2'b00);
                check(l2_gnt, {rsp[1].done, rsp[0].done});
                p = l2_gnt;
            end
            finish(3'b011);
        end
        // random traffic from a random subset of requesters, dma always with core0
        repeat (300)
        begin
            for (int j = 0; j < NUM_REQ; j++)
                cmd[j] = '{1'b1, 1'($urandom), 1'($urandom),
                           modes[$urandom % 3], ($urandom % 4 == 0) ?
                           $urandom : tab[$urandom % 18] ^
                           ($urandom & 32'h0000_3FFC)};
            p = 2'($urandom);
            start({p[0], p});
            finish({p[0], p});
        end
        conclude();
    end
endmodule : memory_map_decode_and_access_tb

// >>> verification/mmda_req_model.sv
// requester model: one core or dma port that re-presents until answered
module mmda_req_model
    import mmda_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  mmda_req_t cmd,
    input  wire logic go,
    input  mmda_rsp_t rsp,
    output mmda_req_t req,
    output logic      busy,
    output mmda_rsp_t got
);
    timeunit 1ns;
    timeprecision 1ps;

    mmda_req_t cmd_q;

    // hold through retries; capture the answer on the edge that shows done
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy  <= 1'b0;
            cmd_q <= '0;
            got   <= '0;
        end
        else if (busy && rsp.done)
        begin
            busy <= 1'b0;
            got  <= rsp;
        end
        else if (go && !busy)
        begin
            busy  <= 1'b1;
            cmd_q <= cmd;
        end
    end

    // valid drops while done shows, so no answered request is taken twice
    always_comb
    begin
        req       = cmd_q;
        req.valid = busy && !rsp.done;
        if (!busy)
        begin
            // released addr, write and fetch lines show the inverse of the stale request
            req.addr  = ~cmd_q.addr;
            req.write = ~cmd_q.write;
            req.fetch = ~cmd_q.fetch;
        end
    end
endmodule : mmda_req_model
